// ===== verification/slbist_asserts.sv
// Link checks between the host end and the deserializer end
`timescale 1ns/1ns
module slbist_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic self_test_enable,
  input wire logic pass,
  input wire logic locked,
  input wire logic pass_b,
  input wire logic en_b
);
  logic [7:0] on_cnt;
  logic [7:0] off_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_cnt <= 8'h00;
      off_cnt <= 8'h00;
    end else begin
      on_cnt <= !self_test_enable ? 8'h00 : on_cnt + {7'h00, on_cnt != 8'hff};
      off_cnt <= self_test_enable ? 8'h00 : off_cnt + {7'h00, off_cnt != 8'hff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_LINK_CLK_HIGH: assert property ($rose(link_clk) |-> link_clk [*5] ##1 !link_clk)
    else $error("link clock high phase wrong");
  AST_DATA_ON_LOW: assert property ($changed(link_data) |-> !link_clk)
    else $error("link data moved while clock high");
  AST_PULSE_WIDTH: assert property ($fell(pass) && self_test_enable |-> (!pass) [*5] ##1 pass)
    else $error("error pulse width wrong");
  AST_PULSE_B: assert property ($fell(pass_b) && en_b |-> (!pass_b) [*5] ##1 pass_b)
    else $error("error pulse width wrong on second link");
  AST_NEW_RUN: assert property ($rose(self_test_enable) |-> ##[1:8] pass)
    else $error("result not cleared by new run");
  AST_EN_AFTER_LOCK: assert property ($rose(self_test_enable) |-> locked)
    else $error("checker enabled before lock");
  AST_CLEAN_PASS: assert property (on_cnt >= 8'h10 |-> pass)
    else $error("false error on clean link");
  AST_FINAL_HIGH: assert property ($fell(self_test_enable) |-> ##8 pass)
    else $error("clean run result not high");
  AST_HELD: assert property (off_cnt >= 8'h10 |-> $stable(pass))
    else $error("held result changed");
endmodule // slbist_asserts

// ===== verification/slbist_bench.sv
// Self-checking bench for both link ends
`timescale 1ns/1ns
module slbist_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pclk_on = 1'b0;
  logic [23:0] pdata = 24'h000000;
  logic [2:0] pctl = 3'h0;
  logic run_req = 1'b0;
  logic pd_n = 1'b1;
  logic pb_prev = 1'b0;
  logic taken, busy, run_done, passed, pv_a, de_a, hs_a, vs_a;
  logic [15:0] ecnt;
  logic [23:0] rgb_a, r0;
  logic [31:0] rs = 32'h117f;
  logic [6:0] ps = 7'h7f;
  int err_count = 0;
  int n_compared = 0;
  int falls = 0;
  int lowc = 0;
  int i, fb;
  int takes = 0;
  int tk0;
  logic de_c, hs_c, vs_c;
  logic [23:0] rgb_c;
  slbist_link_if if_a();
  slbist_link_if if_b();
  slbist_link_if if_c();
  slbist_host #(.LEGACY(1'b0), .SETTLE(1600)) i_slbist_host (.clk(clk), .rst(rst),
    .pixel_clk_on(pclk_on), .pixel_data(pdata), .pixel_de(pctl[2]), .pixel_hs(pctl[1]),
    .pixel_vs(pctl[0]), .pixel_taken(taken), .run_request(run_req), .test_busy(busy),
    .test_done(run_done), .test_passed(passed), .error_count(ecnt), .link(if_a.host));
  slbist_des i_slbist_des (.clk(clk), .rst(rst), .power_down_n(1'b1), .link(if_a.des),
    .rgb_out(rgb_a), .de_out(de_a), .hs_out(hs_a), .vs_out(vs_a), .pixel_valid(pv_a));
  slbist_des i_slbist_des_b (.clk(clk), .rst(rst), .power_down_n(pd_n), .link(if_b.des),
    .rgb_out(), .de_out(), .hs_out(), .vs_out(), .pixel_valid());
  slbist_host #(.LEGACY(1'b1), .SETTLE(1600)) i_slbist_host_c (.clk(clk), .rst(rst),
    .pixel_clk_on(pclk_on), .pixel_data(pdata), .pixel_de(pctl[2]), .pixel_hs(pctl[1]),
    .pixel_vs(pctl[0]), .pixel_taken(), .run_request(1'b0), .test_busy(), .test_done(),
    .test_passed(), .error_count(), .link(if_c.host));
  slbist_des i_slbist_des_c (.clk(clk), .rst(rst), .power_down_n(1'b1), .link(if_c.des),
    .rgb_out(rgb_c), .de_out(de_c), .hs_out(hs_c), .vs_out(vs_c), .pixel_valid());
  slbist_asserts i_slbist_asserts (.clk(clk), .rst(rst), .link_clk(if_a.link_clk),
    .link_data(if_a.link_data), .self_test_enable(if_a.self_test_enable),
    .pass(if_a.pass), .locked(if_a.locked), .pass_b(if_b.pass),
    .en_b(if_b.self_test_enable));

  always #4 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Next 24-bit pattern payload; returns {state, payload}
  function automatic logic [30:0] prbs(input logic [6:0] s);
    logic [23:0] p;
    p = 24'h000000;
    for (int k = 0; k < 24; k++) begin
      s = {s[5:0], s[6] ^ s[5]};
      p = {p[22:0], s[0]};
    end
    return {s, p};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return if_a.locked;
      1: return pv_a;
      2: return if_a.self_test_enable;
      default: return run_done;
    endcase
  endfunction

  // Bounded wait for a flag
  task automatic wt(input int s, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      if (sig(s) === 1'b1) return;
    end
    chk(32'h0, 32'h1);
    test_done();
  endtask

  // One frame on the second link, clock bits in ck
  task automatic send(input logic [23:0] p, input logic [1:0] ck);
    logic [30:0] f;
    f = {ck[1], p, 5'h03, ck[0]};
    for (int k = 30; k >= 0; k--) begin
      @(posedge clk);
      if_b.link_clk <= 1'b0;
      if_b.link_data <= f[k];
      repeat (5) @(posedge clk);
      if_b.link_clk <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic tf(input logic [23:0] m);
    logic [30:0] r;
    r = prbs(ps);
    ps = r[30:24];
    send(r[23:0] ^ m, 2'b10);
  endtask

  // Count and measure error pulses on the second link
  always @(posedge clk) begin
    pb_prev <= if_b.pass;
    if (taken === 1'b1) takes++;
    if (pb_prev && !if_b.pass) falls++;
    if (!if_b.pass) begin
      lowc <= lowc + 1;
    end else begin
      if (lowc > 0 && lowc < 9 && if_b.self_test_enable) chk(lowc, 5);
      lowc <= 0;
    end
  end

  initial begin
    if_b.link_clk = 1'b0;
    if_b.link_data = 1'b0;
    if_b.self_test_enable = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    pclk_on <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wt(0, 4000);
      @(posedge clk);
      pdata <= (i == 0) ? 24'h000000 : rs[23:0];
      pctl <= rs[26:24];
      rs = xs(rs);
      repeat (3) wt(1, 800);
      @(negedge clk);
      chk({de_a, hs_a, vs_a, rgb_a}, {pctl, pdata});
      chk({de_c, hs_c, vs_c, rgb_c}, (pdata == 24'h0) ? 27'h0 : {pctl, pdata});
    end
    chk(takes > 8, 1'b1);
    @(posedge clk);
    run_req <= 1'b1;
    wt(2, 4000);
    chk(busy, 1'b1);
    tk0 = takes;
    repeat (2) wt(1, 800);
    @(negedge clk);
    r0 = rgb_a;
    wt(1, 800);
    @(negedge clk);
    chk({r0 ^ rgb_a, de_a, hs_a, vs_a}, 27'h7fffff8);
    chk(r0 === slbist_pkg::CHECKER_A || r0 === slbist_pkg::CHECKER_B, 1'b1);
    repeat (2000) @(posedge clk);
    chk(takes - tk0, 0);
    run_req <= 1'b0;
    wt(3, 4000);
    @(negedge clk);
    chk({passed, ecnt, if_a.pass, busy}, {1'b1, 16'h0000, 1'b1, 1'b0});
    repeat (8) tf(24'h000000);
    @(negedge clk);
    chk(if_b.locked, 1'b1);
    @(posedge clk);
    if_b.self_test_enable <= 1'b1;
    repeat (3) tf(24'h000000);
    fb = falls;
    for (i = 0; i < 10; i++) begin
      rs = xs(rs);
      tf(i == 0 ? 24'h000001 : i == 1 ? 24'h800000 : i == 2 ? 24'hffffff : rs[23:0] | 24'h1);
      tf(24'h000000);
    end
    @(negedge clk);
    chk(falls - fb, 10);
    @(posedge clk);
    if_b.self_test_enable <= 1'b0;
    repeat (2) tf(24'h000000);
    @(negedge clk);
    chk(if_b.pass, 1'b0);
    repeat (2) tf(24'h000000);
    @(negedge clk);
    chk(falls - fb, 11);
    chk(if_b.pass, 1'b0);
    @(posedge clk);
    if_b.self_test_enable <= 1'b1;
    repeat (3) tf(24'h000000);
    @(negedge clk);
    chk(if_b.pass, 1'b1);
    @(posedge clk);
    if_b.self_test_enable <= 1'b0;
    repeat (2) tf(24'h000000);
    @(negedge clk);
    chk(if_b.pass, 1'b1);
    @(posedge clk);
    pd_n <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({if_b.pass, if_b.locked}, 2'b00);
    @(posedge clk);
    pd_n <= 1'b1;
    repeat (8) tf(24'h000000);
    @(negedge clk);
    chk(if_b.locked, 1'b1);
    rs = xs(rs);
    send(rs[23:0], 2'b01);
    tf(24'h000000);
    @(negedge clk);
    chk(if_b.locked, 1'b0);
    test_done();
  end
endmodule // slbist_bench

// ===== verilog/slbist_des.sv
// Deserializer end: frame recovery, lock status and payload self test checker
`timescale 1ns/1ns
module slbist_des (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_down_n,
  slbist_link_if.des link,
  output logic [23:0] rgb_out,
  output logic de_out,
  output logic hs_out,
  output logic vs_out,
  output logic pixel_valid
);
  // Synchronisers
  logic lc_s1, lc_s2, lc_s3;
  logic ld_s1, ld_s2;
  logic en_s1, en_s2, en_s3;
  logic pd_s1, pd_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lc_s1 <= 1'b0;
      lc_s2 <= 1'b0;
      lc_s3 <= 1'b0;
      ld_s1 <= 1'b0;
      ld_s2 <= 1'b0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_s3 <= 1'b0;
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
    end else begin
      lc_s1 <= link.link_clk;
      lc_s2 <= lc_s1;
      lc_s3 <= lc_s2;
      ld_s1 <= link.link_data;
      ld_s2 <= ld_s1;
      en_s1 <= link.self_test_enable;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      pd_s1 <= power_down_n;
      pd_s2 <= pd_s1;
    end
  end

  logic lc_rise;
  logic test_en;
  logic test_rise;
  logic test_fall;
  assign lc_rise = lc_s2 & ~lc_s3;
  assign test_en = en_s2;
  assign test_rise = en_s2 & ~en_s3;
  assign test_fall = ~en_s2 & en_s3;

  // State
  logic [30:0] sr, next_sr;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic aligned, next_aligned;
  logic [2:0] good_cnt, next_good_cnt;
  logic locked, next_locked;
  logic [6:0] prbs, next_prbs;
  logic seeded, next_seeded;
  logic err_seen, next_err_seen;
  logic result, next_result;
  logic [2:0] pulse_cnt, next_pulse_cnt;
  logic pass, next_pass;
  logic phase, next_phase;
  logic [23:0] next_rgb_out;
  logic next_de_out, next_hs_out, next_vs_out, next_pixel_valid;

  logic frame_end;
  logic frame_ok;
  logic cmd;
  logic [23:0] payload;
  logic [30:0] step;

  always_comb begin
    next_sr = sr;
    next_bit_cnt = bit_cnt;
    next_aligned = aligned;
    next_good_cnt = good_cnt;
    next_locked = locked;
    next_prbs = prbs;
    next_seeded = seeded;
    next_err_seen = err_seen;
    next_result = result;
    next_pulse_cnt = pulse_cnt;
    next_phase = phase;
    next_rgb_out = rgb_out;
    next_de_out = de_out;
    next_hs_out = hs_out;
    next_vs_out = vs_out;
    next_pixel_valid = 1'b0;
    frame_end = 1'b0;
    frame_ok = 1'b0;
    cmd = 1'b0;
    payload = '0;
    step = '0;
    if (pulse_cnt != 3'h0) begin
      next_pulse_cnt = pulse_cnt - 3'h1;
    end
    if (lc_rise) begin
      next_sr = {sr[29:0], ld_s2};
      frame_end = aligned ? (bit_cnt == slbist_pkg::LAST_BIT) : 1'b1;
      frame_ok = next_sr[slbist_pkg::POS_CLK_HI] & ~next_sr[slbist_pkg::POS_CLK_LO];
      payload = next_sr[slbist_pkg::POS_PAY_MSB:slbist_pkg::POS_PAY_LSB];
      cmd = next_sr[slbist_pkg::POS_CODE_A] & next_sr[slbist_pkg::POS_CODE_B];
      next_bit_cnt = bit_cnt + 5'h1;
    end
    if (frame_end) begin
      if (frame_ok) begin
        next_aligned = 1'b1;
        next_bit_cnt = 5'h0;
        if (good_cnt != 3'(slbist_pkg::LOCK_FRAMES)) begin
          next_good_cnt = good_cnt + 3'h1;
        end
        next_locked = (next_good_cnt == 3'(slbist_pkg::LOCK_FRAMES));
      end else begin
        // Embedded clock bits lost
        next_aligned = 1'b0;
        next_good_cnt = 3'h0;
        next_locked = 1'b0;
      end
    end
    if (frame_end && frame_ok && next_locked) begin
      next_pixel_valid = 1'b1;
      if (test_en) begin
        next_phase = ~phase;
        next_rgb_out = phase ? slbist_pkg::CHECKER_B : slbist_pkg::CHECKER_A;
      end else if (cmd) begin
        next_rgb_out = '0;
      end else begin
        next_rgb_out = payload;
      end
      next_de_out = cmd ? 1'b0 : next_sr[slbist_pkg::POS_DE];
      next_hs_out = cmd ? 1'b0 : next_sr[slbist_pkg::POS_HS];
      next_vs_out = cmd ? 1'b0 : next_sr[slbist_pkg::POS_VS];
      if (test_en && cmd) begin
        if (!seeded) begin
          next_prbs = payload[6:0];
          next_seeded = 1'b1;
        end else begin
          step = slbist_pkg::slbist_prbs24(prbs);
          next_prbs = step[30:24];
          if (step[23:0] != payload) begin
            next_err_seen = 1'b1;
            next_pulse_cnt = 3'(slbist_pkg::PASS_PULSE_CYCLES);
          end
        end
      end
    end
    if (!test_en) begin
      next_seeded = 1'b0;
      next_pulse_cnt = 3'h0;
    end
    if (test_rise) begin
      next_err_seen = 1'b0;
    end
    if (test_fall) begin
      next_result = ~err_seen;
    end
    next_pass = test_en ? (next_pulse_cnt == 3'h0) : next_result;
    if (!pd_s2) begin
      next_sr = '0;
      next_bit_cnt = 5'h0;
      next_aligned = 1'b0;
      next_good_cnt = 3'h0;
      next_locked = 1'b0;
      next_prbs = slbist_pkg::PRBS_SEED;
      next_seeded = 1'b0;
      next_err_seen = 1'b0;
      next_result = 1'b0;
      next_pulse_cnt = 3'h0;
      next_pass = 1'b0;
      next_phase = 1'b0;
      next_rgb_out = '0;
      next_de_out = 1'b0;
      next_hs_out = 1'b0;
      next_vs_out = 1'b0;
      next_pixel_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr <= '0;
      bit_cnt <= 5'h0;
      aligned <= 1'b0;
      good_cnt <= 3'h0;
      locked <= 1'b0;
      prbs <= slbist_pkg::PRBS_SEED;
      seeded <= 1'b0;
      err_seen <= 1'b0;
      result <= 1'b0;
      pulse_cnt <= 3'h0;
      pass <= 1'b0;
      phase <= 1'b0;
      rgb_out <= '0;
      de_out <= 1'b0;
      hs_out <= 1'b0;
      vs_out <= 1'b0;
      pixel_valid <= 1'b0;
    end else begin
      sr <= next_sr;
      bit_cnt <= next_bit_cnt;
      aligned <= next_aligned;
      good_cnt <= next_good_cnt;
      locked <= next_locked;
      prbs <= next_prbs;
      seeded <= next_seeded;
      err_seen <= next_err_seen;
      result <= next_result;
      pulse_cnt <= next_pulse_cnt;
      pass <= next_pass;
      phase <= next_phase;
      rgb_out <= next_rgb_out;
      de_out <= next_de_out;
      hs_out <= next_hs_out;
      vs_out <= next_vs_out;
      pixel_valid <= next_pixel_valid;
    end
  end

  assign link.pass = pass;
  assign link.locked = locked;
endmodule // slbist_des

// ===== verilog/slbist_host.sv
// Serializer end with test sequencer and result counter
`timescale 1ns/1ns
module slbist_host #(
  parameter bit LEGACY = 1'b0,
  parameter int SETTLE = slbist_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pixel_clk_on,
  input wire logic [23:0] pixel_data,
  input wire logic pixel_de,
  input wire logic pixel_hs,
  input wire logic pixel_vs,
  output logic pixel_taken,
  input wire logic run_request,
  output logic test_busy,
  output logic test_done,
  output logic test_passed,
  output logic [15:0] error_count,
  slbist_link_if.host link
);
  typedef enum {H_IDLE, H_SER_ON, H_DES_ON, H_DES_OFF, H_SER_OFF} slbist_hstate_t;

  logic p_s1, p_s2, p_s3;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p_s1 <= 1'b1;
      p_s2 <= 1'b1;
      p_s3 <= 1'b1;
    end else begin
      p_s1 <= link.pass;
      p_s2 <= p_s1;
      p_s3 <= p_s2;
    end
  end

  slbist_hstate_t st, next_st;
  logic [11:0] wait_cnt, next_wait_cnt;
  logic ser_en, next_ser_en;
  logic des_en, next_des_en;
  logic next_test_done, next_test_passed;
  logic [15:0] next_error_count;
  logic [3:0] div_cnt, next_div_cnt;
  logic lclk, next_lclk;
  logic [30:0] sh, next_sh;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [6:0] prbs, next_prbs;
  logic next_pixel_taken;
  logic ser_test;
  logic [30:0] step;
  logic [30:0] frame;

  // Legacy serializer has no enable: zero data requests the test
  assign ser_test = LEGACY ? (pixel_data == 24'h000000) : ser_en;

  always_comb begin
    next_st = st;
    next_wait_cnt = wait_cnt;
    next_ser_en = ser_en;
    next_des_en = des_en;
    next_test_done = 1'b0;
    next_test_passed = test_passed;
    next_error_count = error_count;
    case (st)
      H_IDLE: begin
        if (run_request && pixel_clk_on) begin
          next_ser_en = 1'b1;
          next_wait_cnt = 12'(SETTLE);
          next_st = H_SER_ON;
        end
      end
      H_SER_ON: begin
        if (wait_cnt != 12'h0) begin
          next_wait_cnt = wait_cnt - 12'h1;
        end else begin
          next_des_en = 1'b1;
          next_error_count = 16'h0000;
          next_st = H_DES_ON;
        end
      end
      H_DES_ON: begin
        if (~p_s2 & p_s3 && error_count != 16'hffff) begin
          next_error_count = error_count + 16'h0001;
        end
        if (!run_request) begin
          next_des_en = 1'b0;
          next_wait_cnt = 12'(SETTLE);
          next_st = H_DES_OFF;
        end
      end
      H_DES_OFF: begin
        if (wait_cnt != 12'h0) begin
          next_wait_cnt = wait_cnt - 12'h1;
        end else begin
          next_test_passed = p_s2;
          next_test_done = 1'b1;
          next_ser_en = 1'b0;
          next_st = H_SER_OFF;
        end
      end
      H_SER_OFF: begin
        if (!run_request) begin
          next_st = H_IDLE;
        end
      end
      default: begin
        next_st = H_IDLE;
      end
    endcase
  end

  always_comb begin
    next_div_cnt = div_cnt;
    next_lclk = lclk;
    next_sh = sh;
    next_bit_cnt = bit_cnt;
    next_prbs = prbs;
    next_pixel_taken = 1'b0;
    step = slbist_pkg::slbist_prbs24(prbs);
    frame = '0;
    frame[slbist_pkg::POS_CLK_HI] = 1'b1;
    if (ser_test) begin
      frame[slbist_pkg::POS_PAY_MSB:slbist_pkg::POS_PAY_LSB] = step[23:0];
      frame[slbist_pkg::POS_CODE_A] = 1'b1;
      frame[slbist_pkg::POS_CODE_B] = 1'b1;
    end else begin
      frame[slbist_pkg::POS_PAY_MSB:slbist_pkg::POS_PAY_LSB] = pixel_data;
      frame[slbist_pkg::POS_DE] = pixel_de;
      frame[slbist_pkg::POS_HS] = pixel_hs;
      frame[slbist_pkg::POS_VS] = pixel_vs;
    end
    if (!pixel_clk_on) begin
      next_div_cnt = 4'h0;
      next_lclk = 1'b0;
    end else if (div_cnt == 4'(slbist_pkg::LINK_HALF_CYCLES - 1)) begin
      next_div_cnt = 4'h0;
      next_lclk = ~lclk;
      if (lclk) begin
        if (bit_cnt == slbist_pkg::LAST_BIT) begin
          next_sh = frame;
          next_bit_cnt = 5'h0;
          next_pixel_taken = ~ser_test;
          if (ser_test) begin
            next_prbs = step[30:24];
          end
        end else begin
          next_sh = {sh[29:0], 1'b0};
          next_bit_cnt = bit_cnt + 5'h1;
        end
      end
    end else begin
      next_div_cnt = div_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= H_IDLE;
      wait_cnt <= 12'h0;
      ser_en <= 1'b0;
      des_en <= 1'b0;
      test_done <= 1'b0;
      test_passed <= 1'b0;
      error_count <= 16'h0000;
      div_cnt <= 4'h0;
      lclk <= 1'b0;
      sh <= '0;
      bit_cnt <= slbist_pkg::LAST_BIT;
      prbs <= slbist_pkg::PRBS_SEED;
      pixel_taken <= 1'b0;
    end else begin
      st <= next_st;
      wait_cnt <= next_wait_cnt;
      ser_en <= next_ser_en;
      des_en <= next_des_en;
      test_done <= next_test_done;
      test_passed <= next_test_passed;
      error_count <= next_error_count;
      div_cnt <= next_div_cnt;
      lclk <= next_lclk;
      sh <= next_sh;
      bit_cnt <= next_bit_cnt;
      prbs <= next_prbs;
      pixel_taken <= next_pixel_taken;
    end
  end

  assign test_busy = (st != H_IDLE);
  assign link.link_clk = lclk;
  assign link.link_data = sh[slbist_pkg::POS_CLK_HI];
  assign link.self_test_enable = des_en;
endmodule // slbist_host

// ===== verilog/slbist_link_if.sv
// Serial link and self test pins between the two ends
`timescale 1ns/1ns
interface slbist_link_if;
  logic link_clk;
  logic link_data;
  logic self_test_enable;
  logic pass;
  logic locked;

  modport des (
    input link_clk,
    input link_data,
    input self_test_enable,
    output pass,
    output locked
  );

  modport host (
    output link_clk,
    output link_data,
    output self_test_enable,
    input pass,
    input locked
  );
endinterface

// ===== verilog/slbist_pkg.sv
// Shared constants and pattern function for the link self test
package slbist_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int PASS_PULSE_CYCLES = LINK_HALF_CYCLES;
  localparam int PAYLOAD_BITS = 24;
  localparam int FRAME_BITS = 31;
  localparam int LOCK_FRAMES = 4;
  localparam int SETTLE_CYCLES = (LOCK_FRAMES + 2) * FRAME_BITS * 2 * LINK_HALF_CYCLES;
  localparam int POS_CLK_HI = 30;
  localparam int POS_PAY_MSB = 29;
  localparam int POS_PAY_LSB = 6;
  localparam int POS_DE = 5;
  localparam int POS_HS = 4;
  localparam int POS_VS = 3;
  localparam int POS_CODE_A = 2;
  localparam int POS_CODE_B = 1;
  localparam int POS_CLK_LO = 0;
  localparam logic [6:0] PRBS_SEED = 7'h7f;
  localparam logic [23:0] CHECKER_A = 24'haaaaaa;
  localparam logic [23:0] CHECKER_B = 24'h555555;
  localparam logic [4:0] LAST_BIT = 5'h1e;

  // Advance a PRBS7 (x^7 + x^6 + 1) state by one payload; returns {state, payload}
  function automatic logic [30:0] slbist_prbs24(input logic [6:0] s);
    logic [6:0] st;
    logic [23:0] p;
    logic b;
    st = s;
    p = '0;
    for (int i = 0; i < PAYLOAD_BITS; i++) begin
      b = st[6] ^ st[5];
      st = {st[5:0], b};
      p = {p[22:0], b};
    end
    return {st, p};
  endfunction
endpackage
